// ==== src/sleep_mon_pkg.sv ====
// Purpose: constants for the sleep-mode wake-up timer and battery monitor
// Assumes: 100 MHz mclk, 32.768 kHz low-frequency tick enable
// Notes: register offsets are byte addresses of the serial register port
package sleep_mon_pkg;
	// ==========================================
	// register offsets
	localparam logic [6:0] ADDR_WAKE_EXP_DIV = 7'h14;
	localparam logic [6:0] ADDR_WAKE_MANT_HI = 7'h15;
	localparam logic [6:0] ADDR_WAKE_MANT_LO = 7'h16;
	localparam logic [6:0] ADDR_WAKE_CNT_HI = 7'h17;
	localparam logic [6:0] ADDR_WAKE_CNT_LO = 7'h18;
	localparam logic [6:0] ADDR_BAT_THRESH = 7'h1A;
	localparam logic [6:0] ADDR_BAT_LEVEL = 7'h1B;
	localparam logic [6:0] ADDR_IRQ_STATUS1 = 7'h03;
	localparam logic [6:0] ADDR_IRQ_STATUS2 = 7'h04;
	// ==========================================
	// field positions
	localparam int EXP_LSB = 2;
	localparam int DIV_LSB = 0;
	localparam int STAT2_BAT_BIT = 2;
	localparam int STAT2_WAKE_BIT = 3;
	// ==========================================
	// reset values
	localparam logic [7:0] RST_WAKE_EXP_DIV = 8'h00;
	localparam logic [7:0] RST_WAKE_MANT = 8'h00;
	localparam logic [4:0] RST_BAT_THRESH = 5'h14;
	// ==========================================
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int LF_HZ = 32_768;
	localparam int LF_DIV = CLK_HZ / LF_HZ;
	localparam int SAMPLE_PERIOD_S = 1;
	localparam int SAMPLE_TICKS = SAMPLE_PERIOD_S * LF_HZ;
	localparam int MEAS_US = 250;
	localparam int MEAS_CYCLES = MEAS_US * (CLK_HZ / 1_000_000);
	localparam int BASE_SHIFT = 5;
	localparam int LOW_READS = 4;
	typedef enum logic [2:0] {
		WK_IDLE = 3'b001,
		WK_RUN = 3'b010,
		WK_DONE = 3'b100
	} wake_state_e;
endpackage : sleep_mon_pkg

// ==== src/sleep_mon.sv ====
// Purpose: wake-up timer and periodic battery monitor for sleep mode
// Assumes: register port strobes are synchronous to mclk
// Notes: low-frequency ticks are derived from mclk or a synced crystal pin
//
// Function
// R1 - timer starts counting when sleep entered with timer-run enable set
// R2 - period is 32*M*2^(R-D) ticks of the 32.768 kHz clock
// R3 - R is 4 bits, D 2 bits; mantissa high byte then low byte
// R4 - expiry with wake interrupt enabled asserts the interrupt pin
// R5 - current 16-bit count readable through two read-only registers
// R6 - enabled expiry drives pin low and requests crystal and mcu clock
// R7 - disabled wake interrupt: state held until host commands a change
// R8 - crystal select reconfigures GPIO0 as the crystal connection
// R9 - crystal select moves timer, mcu clock and duty cycle to crystal
// R10 - level below threshold with battery interrupt enabled raises interrupt
// R11 - latest level code readable while monitor enabled
// R12 - level code is 5 bits, 1.7 V plus 50 mV per step
// R13 - detector powered once per second for about 250 us
// R14 - four consecutive low readings needed before interrupt
// R15 - monitor enabled in sleep starts the RC oscillator; code keeps it off while crystal is selected
// R16 - host reads both status registers to find the source
// R17 - pending interrupt keeps mcu clock running until read
// R18 - flags latch until the status register is read
`timescale 1ns/1ps
`default_nettype none
module sleep_mon
	import sleep_mon_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register port
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// mode control bits
	input wire logic sleep_mode,
	input wire logic timer_run_en,
	input wire logic wake_irq_en,
	input wire logic bat_irq_en,
	input wire logic bat_mon_en,
	input wire logic ext_xtal32_select,
	// crystal and detector
	input wire logic xtal32_pin,
	input wire logic [4:0] bat_adc_code,
	// outputs
	output logic irq_n_pin,
	output logic rc_osc_on,
	output logic gpio0_is_xtal,
	output logic lf_from_xtal,
	output logic detector_power,
	output logic wake_timer_gpio,
	output logic xtal30_req,
	output logic mcu_clk_hold
);
	// ==========================================
	// registers
	logic [7:0] exp_div_r;
	logic [7:0] mant_hi_r;
	logic [7:0] mant_lo_r;
	logic [4:0] thresh_r;
	logic [4:0] level_r;
	logic [15:0] wcount_r;
	logic wake_flag_r;
	logic bat_flag_r;
	logic [7:0] rdata_nxt;
	// writes to read-only or unmapped offsets fall through untouched
	always_ff @(posedge mclk) begin
		if (sys_rst)
			exp_div_r <= RST_WAKE_EXP_DIV;
		else if (reg_wr && reg_addr == ADDR_WAKE_EXP_DIV)
			exp_div_r <= {2'h0, reg_wdata[5:0]}; // [R3]
	end
	always_ff @(posedge mclk) begin
		if (sys_rst)
			mant_hi_r <= RST_WAKE_MANT;
		else if (reg_wr && reg_addr == ADDR_WAKE_MANT_HI)
			mant_hi_r <= reg_wdata; // [R3]
	end
	always_ff @(posedge mclk) begin
		if (sys_rst)
			mant_lo_r <= RST_WAKE_MANT;
		else if (reg_wr && reg_addr == ADDR_WAKE_MANT_LO)
			mant_lo_r <= reg_wdata; // [R3]
	end
	always_ff @(posedge mclk) begin
		if (sys_rst)
			thresh_r <= RST_BAT_THRESH;
		else if (reg_wr && reg_addr == ADDR_BAT_THRESH)
			thresh_r <= reg_wdata[4:0]; // [R10]
	end
	always_comb begin
		case (reg_addr)
			ADDR_WAKE_EXP_DIV: rdata_nxt = exp_div_r;
			ADDR_WAKE_MANT_HI: rdata_nxt = mant_hi_r;
			ADDR_WAKE_MANT_LO: rdata_nxt = mant_lo_r;
			ADDR_WAKE_CNT_HI: rdata_nxt = wcount_r[15:8]; // [R5]
			ADDR_WAKE_CNT_LO: rdata_nxt = wcount_r[7:0]; // [R5]
			ADDR_BAT_THRESH: rdata_nxt = {3'h0, thresh_r};
			ADDR_BAT_LEVEL: rdata_nxt = {3'h0, level_r}; // [R11] [R12]
			ADDR_IRQ_STATUS2: begin
				rdata_nxt = 8'h00;
				rdata_nxt[STAT2_WAKE_BIT] = wake_flag_r;
				rdata_nxt[STAT2_BAT_BIT] = bat_flag_r;
			end
			default: rdata_nxt = 8'h00;
		endcase
	end
	// count bytes come one read apart, so the pair can tear mid-count
	always_ff @(posedge mclk) begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
	end
	// ==========================================
	// low-frequency tick source
	// xs3_r only delays xs2_r for the edge detect
	logic xs1_r, xs2_r, xs3_r;
	logic [11:0] lf_div_r;
	logic lf_tick;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			xs1_r <= 1'b0;
			xs2_r <= 1'b0;
			xs3_r <= 1'b0;
		end else begin
			xs1_r <= xtal32_pin;
			xs2_r <= xs1_r;
			xs3_r <= xs2_r;
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst || lf_div_r == 12'(LF_DIV - 1))
			lf_div_r <= 12'h000;
		else
			lf_div_r <= lf_div_r + 12'h001;
	end
	// crystal edges replace the divided mclk tick once selected
	assign lf_tick = ext_xtal32_select ? (xs2_r & ~xs3_r) // [R9]
		: (lf_div_r == 12'(LF_DIV - 1));
	// ==========================================
	// clock source status
	always_ff @(posedge mclk) begin
		if (sys_rst)
			gpio0_is_xtal <= 1'b0;
		else
			gpio0_is_xtal <= ext_xtal32_select; // [R8]
	end
	always_ff @(posedge mclk) begin
		if (sys_rst)
			lf_from_xtal <= 1'b0;
		else
			lf_from_xtal <= ext_xtal32_select; // [R9]
	end
	// rc oscillator rests whenever the crystal carries the slow clock
	always_ff @(posedge mclk) begin
		if (sys_rst)
			rc_osc_on <= 1'b0;
		else
			rc_osc_on <= ~ext_xtal32_select & sleep_mode
				& (bat_mon_en | timer_run_en); // [R15]
	end
	// ==========================================
	// wake-up timer
	wake_state_e wstate_r;
	logic [3:0] wexp;
	logic [1:0] wdiv;
	logic [4:0] shift_amt;
	logic [20:0] pre_lim;
	logic [20:0] pre_r;
	logic [15:0] mant;
	logic sleep_d_r;
	logic wake_expire;
	logic stat_read;
	assign wexp = exp_div_r[EXP_LSB +: 4];
	assign wdiv = exp_div_r[DIV_LSB +: 2];
	assign mant = {mant_hi_r, mant_lo_r};
	// a mantissa of zero runs the full 65536 steps
	// 32*2^(R-D) ticks per mantissa step; smallest is 4 ticks at R=0 D=3
	assign shift_amt = (5'(wexp) + 5'(BASE_SHIFT)) - 5'(wdiv); // [R2]
	assign pre_lim = 21'h000001 << shift_amt; // [R2]
	assign wake_expire = (wstate_r == WK_RUN) && lf_tick
		&& (pre_r >= pre_lim - 21'h000001)
		&& (wcount_r >= mant - 16'h0001);
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wstate_r <= WK_IDLE;
			pre_r <= 21'h000000;
			wcount_r <= 16'h0000;
			sleep_d_r <= 1'b0;
		end else begin
			sleep_d_r <= sleep_mode;
			case (wstate_r)
				WK_IDLE: begin
					if (sleep_mode && !sleep_d_r && timer_run_en) begin // [R1]
						wstate_r <= WK_RUN;
						pre_r <= 21'h000000;
						wcount_r <= 16'h0000;
					end
				end
				WK_RUN: begin
					if (!timer_run_en)
						wstate_r <= WK_IDLE;
					else if (wake_expire)
						wstate_r <= WK_DONE;
					else if (lf_tick) begin
						if (pre_r >= pre_lim - 21'h000001) begin
							pre_r <= 21'h000000;
							wcount_r <= wcount_r + 16'h0001;
						end else
							pre_r <= pre_r + 21'h000001;
					end
				end
				WK_DONE: begin
					// restart periodically while still asleep
					if (timer_run_en && sleep_mode) begin
						wstate_r <= WK_RUN;
						pre_r <= 21'h000000;
						wcount_r <= 16'h0000;
					end else
						wstate_r <= WK_IDLE;
				end
				default: wstate_r <= WK_IDLE;
			endcase
		end
	end
	// ==========================================
	// battery monitor
	logic [15:0] samp_r;
	logic [14:0] meas_r;
	logic [2:0] low_cnt_r;
	logic meas_end;
	assign meas_end = detector_power && meas_r == 15'(MEAS_CYCLES - 1);
	always_ff @(posedge mclk) begin
		if (sys_rst || !bat_mon_en) begin
			samp_r <= 16'h0000;
			meas_r <= 15'h0000;
			detector_power <= 1'b0;
		end else begin
			if (lf_tick) begin
				if (samp_r == 16'(SAMPLE_TICKS - 1)) begin
					samp_r <= 16'h0000;
					detector_power <= 1'b1; // [R13]
				end else
					samp_r <= samp_r + 16'h0001;
			end
			if (meas_end) begin
				detector_power <= 1'b0; // [R13]
				meas_r <= 15'h0000;
			end else if (detector_power)
				meas_r <= meas_r + 15'h0001;
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst)
			level_r <= 5'h00;
		else if (meas_end)
			level_r <= bat_adc_code; // [R11] [R12]
	end
	// saturates: one interrupt per low spell, rearmed by a good reading
	always_ff @(posedge mclk) begin
		if (sys_rst)
			low_cnt_r <= 3'h0;
		else if (meas_end && bat_adc_code >= thresh_r)
			low_cnt_r <= 3'h0;
		else if (meas_end && low_cnt_r != 3'(LOW_READS)) // [R14]
			low_cnt_r <= low_cnt_r + 3'h1;
	end
	// ==========================================
	// interrupt flags, set wins over read clear
	logic bat_event;
	assign stat_read = reg_rd && (reg_addr == ADDR_IRQ_STATUS2); // [R16]
	assign bat_event = meas_end && bat_adc_code < thresh_r
		&& low_cnt_r == 3'(LOW_READS - 1); // [R10] [R14]
	event_latch event_latch_wake_i (
		.mclk,
		.sys_rst,
		.set_ev(wake_expire && wake_irq_en), // [R4]
		.clr_ev(stat_read), // [R18]
		.flag(wake_flag_r)
	);
	event_latch event_latch_bat_i (
		.mclk,
		.sys_rst,
		.set_ev(bat_event && bat_irq_en), // [R10] [R14]
		.clr_ev(stat_read), // [R18]
		.flag(bat_flag_r)
	);
	logic pend;
	assign pend = wake_flag_r | bat_flag_r;
	// ==========================================
	// interrupt pin and clock requests
	always_ff @(posedge mclk) begin
		if (sys_rst)
			irq_n_pin <= 1'b1;
		else
			irq_n_pin <= ~pend; // [R4] [R6]
	end
	always_ff @(posedge mclk) begin
		if (sys_rst)
			xtal30_req <= 1'b0;
		else
			xtal30_req <= pend; // [R6] [R17]
	end
	always_ff @(posedge mclk) begin
		if (sys_rst)
			mcu_clk_hold <= 1'b0;
		else
			mcu_clk_hold <= pend; // [R17]
	end
	// without the interrupt only the gpio level reports expiry
	always_ff @(posedge mclk) begin
		if (sys_rst)
			wake_timer_gpio <= 1'b0;
		else if (wake_expire && !wake_irq_en)
			wake_timer_gpio <= 1'b1; // [R7]
		else if (!sleep_mode)
			wake_timer_gpio <= 1'b0; // [R7]
	end
endmodule : sleep_mon
// ==========================================
// sticky interrupt flag; a same-cycle event beats the read clear
module event_latch (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// event and read clear
	input wire logic set_ev,
	input wire logic clr_ev,
	// latched flag
	output logic flag
);
	always_ff @(posedge mclk) begin
		if (sys_rst)
			flag <= 1'b0;
		else if (set_ev)
			flag <= 1'b1; // [R18]
		else if (clr_ev)
			flag <= 1'b0; // [R18]
	end
endmodule : event_latch
`default_nettype wire

// ==== tb/sleep_mon_sva.sv ====
// Purpose: port checks on the sleep-mode monitor
// Assumes: one mclk domain, sys_rst synchronous active high
// Notes: irq follows the status flags one register stage late
`timescale 1ns/1ps
`default_nettype none
module sleep_mon_sva
	import sleep_mon_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register port
	input wire logic [6:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// mode bits
	input wire logic sleep_mode,
	input wire logic wake_irq_en,
	input wire logic bat_irq_en,
	input wire logic bat_mon_en,
	input wire logic ext_xtal32_select,
	// outputs
	input wire logic irq_n_pin,
	input wire logic rc_osc_on,
	input wire logic gpio0_is_xtal,
	input wire logic lf_from_xtal,
	input wire logic mcu_clk_hold
);
	// ==========
	// properties
	logic clr;
	assign clr = reg_rd && reg_addr == ADDR_IRQ_STATUS2;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	AST_IRQ_HOLD: assert property (
		!irq_n_pin && !clr && !$past(clr) |=> !irq_n_pin)
		else $error("irq released without status read");
	AST_IRQ_CLEAR: assert property (
		!irq_n_pin && clr |-> ##[1:3] irq_n_pin)
		else $error("irq not released by status read");
	AST_IRQ_CAUSE: assert property (
		$fell(irq_n_pin) |-> wake_irq_en || bat_irq_en)
		else $error("irq without enabled source");
	AST_MCU_HOLD: assert property (
		!irq_n_pin [*3] |-> mcu_clk_hold)
		else $error("mcu clock dropped while irq pending");
	AST_XTAL_GPIO: assert property (
		$stable(ext_xtal32_select) [*3] |-> gpio0_is_xtal == ext_xtal32_select)
		else $error("gpio0 role differs from crystal select");
	AST_LF_SRC: assert property (
		$stable(ext_xtal32_select) [*3] |-> lf_from_xtal == ext_xtal32_select)
		else $error("slow clock source differs from select");
	AST_RC_OSC: assert property (
		(sleep_mode && bat_mon_en && !ext_xtal32_select) [*3] |-> rc_osc_on)
		else $error("rc oscillator off with monitor in sleep");
	AST_RDATA_HOLD: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	cover property ($fell(irq_n_pin));
	cover property (!irq_n_pin && clr);
	cover property (rc_osc_on);
endmodule : sleep_mon_sva
bind sleep_mon sleep_mon_sva sleep_mon_sva_i (.mclk, .sys_rst, .reg_addr,
	.reg_rd, .reg_rdata, .sleep_mode, .wake_irq_en, .bat_irq_en, .bat_mon_en,
	.ext_xtal32_select, .irq_n_pin, .rc_osc_on, .gpio0_is_xtal, .lf_from_xtal,
	.mcu_clk_hold);
`default_nettype wire

// ==== tb/host_model.sv ====
// Purpose: host controller on the register port
// Assumes: strobes change 1 ns after the mclk rising edge
// Notes: read data taken two edges after the strobe edge
`timescale 1ns/1ps
`default_nettype none
module host_model
	import sleep_mon_pkg::*;
(
	// clock
	input wire logic mclk,
	// register port
	output logic [6:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// ==========
	// bus cycles
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
	end
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge mclk);
		#1;
		{reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		// stale data must not look valid
		reg_wdata = ~v;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		@(posedge mclk);
		#1;
		{reg_addr, reg_rd} = {a, 1'b1};
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		@(posedge mclk);
		#1;
		v = reg_rdata;
	endtask : rd
	// status 1 first: flags clear on the status 2 read
	task automatic service(output logic [7:0] s2);
		logic [7:0] s1;
		rd(ADDR_IRQ_STATUS1, s1);
		rd(ADDR_IRQ_STATUS2, s2);
	endtask : service
endmodule : host_model
`default_nettype wire

// ==== tb/sleep_mon_tb.sv ====
// Purpose: directed test of the sleep-mode monitor
// Assumes: crystal pin toggles every 40 ns, 8 mclk per tick
// Notes: battery sampling is too slow to reach in this run
`timescale 1ns/1ps
`default_nettype none
module sleep_mon_tb;
	import sleep_mon_pkg::*;
	logic mclk, sys_rst, reg_wr, reg_rd, sleep_mode, timer_run_en;
	logic wake_irq_en, bat_irq_en, bat_mon_en, ext_xtal32_select, xtal32_pin;
	logic irq_n_pin, rc_osc_on, gpio0_is_xtal, lf_from_xtal, xtal30_req;
	logic mcu_clk_hold, detector_power, wake_timer_gpio;
	logic [4:0] bat_code;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	longint t0;
	int miscompares = 0;
	int n_tests = 0;
	sleep_mon sleep_mon_i (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .sleep_mode, .timer_run_en, .wake_irq_en,
		.bat_irq_en, .bat_mon_en, .ext_xtal32_select, .xtal32_pin,
		.bat_adc_code(bat_code), .irq_n_pin, .rc_osc_on, .gpio0_is_xtal,
		.lf_from_xtal, .detector_power, .wake_timer_gpio, .xtal30_req,
		.mcu_clk_hold);
	host_model host_model_i (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);
	always #5 mclk = ~mclk;
	always #40 xtal32_pin = ~xtal32_pin;
	// ==========
	// helpers
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %0t: byte %h, want %h", $time, g, e);
		end
	endtask : chk8
	task automatic chk1(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %0t: bit %b, want %b", $time, g, e);
		end
	endtask : chk1
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] v;
		host_model_i.rd(a, v);
		chk8(v, e);
	endtask : rchk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic print_verdict;
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	initial begin
		#200_000;
		miscompares++;
		print_verdict();
	end
	// ==========
	// tests
	initial begin
		{mclk, xtal32_pin, sleep_mode, timer_run_en, wake_irq_en} = '0;
		{bat_mon_en, ext_xtal32_select, bat_irq_en, sys_rst} = 4'b0001;
		bat_code = 5'h1F;
		tick(10);
		sys_rst = 1'b0;
		rchk(ADDR_WAKE_EXP_DIV, RST_WAKE_EXP_DIV);
		rchk(ADDR_WAKE_MANT_HI, RST_WAKE_MANT);
		rchk(ADDR_BAT_THRESH, {3'h0, RST_BAT_THRESH});
		rchk(7'h7F, 8'h00);
		// R=1 D=1 M=2: 64 crystal ticks
		host_model_i.wr(ADDR_WAKE_EXP_DIV, 8'h05);
		host_model_i.wr(ADDR_WAKE_MANT_LO, 8'h02);
		host_model_i.wr(ADDR_WAKE_CNT_LO, 8'hFF);
		rchk(ADDR_WAKE_CNT_LO, 8'h00);
		rchk(ADDR_WAKE_EXP_DIV, 8'h05);
		rchk(ADDR_WAKE_MANT_LO, 8'h02);
		{ext_xtal32_select, timer_run_en, wake_irq_en} = 3'b111;
		tick(4);
		chk1(gpio0_is_xtal, 1'b1);
		chk1(lf_from_xtal, 1'b1);
		sleep_mode = 1'b1;
		t0 = $time;
		// one mantissa step is 32 ticks, about 256 mclk
		tick(300);
		host_model_i.rd(ADDR_WAKE_CNT_LO, d);
		chk8(d, 8'h01);
		repeat (2000) if (irq_n_pin) @(posedge mclk);
		#1;
		chk1(($time - t0) / 10 inside {[495:540]}, 1'b1);
		chk1(irq_n_pin, 1'b0);
		tick(3);
		chk1(xtal30_req, 1'b1);
		chk1(mcu_clk_hold, 1'b1);
		chk1(wake_timer_gpio, 1'b0);
		tick(50);
		chk1(irq_n_pin, 1'b0);
		host_model_i.service(d);
		chk8(d, 8'h01 << STAT2_WAKE_BIT);
		sleep_mode = 1'b0;
		tick(2);
		chk1(irq_n_pin, 1'b1);
		// reset again, then run with the wake irq masked
		sys_rst = 1'b1;
		tick(3);
		{sys_rst, wake_irq_en} = 2'b00;
		host_model_i.wr(ADDR_WAKE_EXP_DIV, 8'h05);
		host_model_i.wr(ADDR_WAKE_MANT_LO, 8'h02);
		sleep_mode = 1'b1;
		tick(700);
		chk1(irq_n_pin, 1'b1);
		chk1(xtal30_req, 1'b0);
		chk1(wake_timer_gpio, 1'b1);
		{ext_xtal32_select, bat_mon_en} = 2'b01;
		tick(4);
		chk1(rc_osc_on, 1'b1);
		chk1(lf_from_xtal, 1'b0);
		chk1(detector_power, 1'b0);
		rchk(ADDR_BAT_LEVEL, 8'h00);
		print_verdict();
	end
endmodule : sleep_mon_tb
`default_nettype wire
